//--- hdl/itc_pkg.sv
package itc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ITC_OFF_CORE = 8'h00;
  localparam logic [7:0] ITC_OFF_IC1 = 8'h04;
  localparam logic [7:0] ITC_OFF_IC2 = 8'h08;
  localparam logic [7:0] ITC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] ITC_OFF_EXTFLAG = 8'h10;

  // core_control fields
  localparam int ITC_CC_VAR = 15;
  localparam int ITC_CC_EXT = 3;

  // interrupt_control_one fields
  localparam int ITC_IC1_NEST = 15;
  localparam int ITC_IC1_OVA = 14;
  localparam int ITC_IC1_OVB = 13;
  localparam int ITC_IC1_CVA = 12;
  localparam int ITC_IC1_CVB = 11;
  localparam int ITC_IC1_OVA_EN = 10;
  localparam int ITC_IC1_OVB_EN = 9;
  localparam int ITC_IC1_CAT_EN = 8;
  localparam int ITC_IC1_SHIFT = 7;
  localparam int ITC_IC1_DIV0 = 6;
  localparam int ITC_IC1_MATH = 4;
  localparam int ITC_IC1_ADDR = 3;
  localparam int ITC_IC1_STACK = 2;
  localparam int ITC_IC1_OSC = 1;
  localparam logic [15:0] ITC_IC1_CTRL_MASK = 16'h8700;
  localparam logic [15:0] ITC_IC1_FLAG_MASK = 16'h78DE;

  // interrupt_control_two fields
  localparam int ITC_IC2_GLOBAL_EN = 15;
  localparam int ITC_IC2_TIMED_DIS = 14;
  localparam int ITC_IC2_SW_TRAP = 13;
  localparam int ITC_IC2_ALT = 8;
  localparam logic [15:0] ITC_IC2_RW_MASK = 16'hA10F;
  localparam logic [15:0] ITC_IC2_RESET = 16'h8000;

  // cpu_status_word priority low bits
  localparam int ITC_STAT_LOW_LSB = 5;
  localparam logic [3:0] ITC_LEVEL_TOP_LOW = 4'h7;

  localparam logic [1:0] ITC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ITC_RESP_SLVERR = 2'h2;

endpackage : itc_pkg

//--- hdl/itc_regs.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module itc_regs
  import itc_pkg::*;
#(
  parameter int N_EXT = 4
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trap events from the core, one-cycle pulses
  input wire logic acc_a_ovf_evt,
  input wire logic acc_b_ovf_evt,
  input wire logic acc_a_cat_evt,
  input wire logic acc_b_cat_evt,
  input wire logic shift_err_evt,
  input wire logic div_zero_evt,
  input wire logic addr_err_evt,
  input wire logic stack_err_evt,
  input wire logic osc_fail_evt,
  input wire logic sw_trap_evt,
  // core priority bookkeeping
  input wire logic level_load,
  input wire logic [3:0] level_value,
  input wire logic irq_in_service,
  input wire logic timed_disable_active,
  // external interrupt pins
  input wire logic [N_EXT-1:0] ext_irq_pin,
  // control outputs to the core
  output logic trap_request,
  output logic latency_variable,
  output logic [3:0] cpu_priority_level,
  output logic irq_gate_open,
  output logic alternate_table_select,
  output logic software_trap_status,
  output logic [N_EXT-1:0] ext_irq_flag
);

  // only four polarity bits exist, so a wider pin set cannot be served
  if (N_EXT < 1 || N_EXT > 4)
  begin : g_bad_n_ext
    $error("N_EXT must be 1 to 4, polarity field holds four bits");
  end

  logic var_lat;
  logic ext_bit;
  logic [2:0] low_bits;
  logic [15:0] ic1_ctrl;
  logic [15:0] ic1_flags;
  logic [15:0] ic2_ctrl;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [N_EXT-1:0] sync_a;
  logic [N_EXT-1:0] sync_b;
  logic [N_EXT-1:0] pin_prev;
  logic trap_seen;
  logic [N_EXT-1:0] ext_flag;

  // write channel capture; address and data may come in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr[7:0];
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_have_aw = aw_held || aw_take;
  wire wr_have_w = w_held || w_take;
  wire wr_fire = wr_have_aw && wr_have_w && !s_axi_bvalid;
  wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [15:0] wd = wr_data[15:0];

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // address decode for writes
  wire wr_core = wr_fire && (wr_addr == ITC_OFF_CORE);
  wire wr_ic1 = wr_fire && (wr_addr == ITC_OFF_IC1);
  wire wr_ic2 = wr_fire && (wr_addr == ITC_OFF_IC2);
  wire wr_stat = wr_fire && (wr_addr == ITC_OFF_STATUS);
  wire wr_ext = wr_fire && (wr_addr == ITC_OFF_EXTFLAG);
  wire wr_hit = wr_core || wr_ic1 || wr_ic2 || wr_stat || wr_ext;

  // trap gating by the enable bits
  wire ova_trap = acc_a_ovf_evt && ic1_ctrl[ITC_IC1_OVA_EN];
  wire ovb_trap = acc_b_ovf_evt && ic1_ctrl[ITC_IC1_OVB_EN];
  wire cva_trap = acc_a_cat_evt && ic1_ctrl[ITC_IC1_CAT_EN];
  wire cvb_trap = acc_b_cat_evt && ic1_ctrl[ITC_IC1_CAT_EN];
  wire math_trap = ova_trap || ovb_trap || cva_trap || cvb_trap || shift_err_evt || div_zero_evt;
  wire swt_trap = sw_trap_evt && ic2_ctrl[ITC_IC2_SW_TRAP];

  // hardware set vector for interrupt_control_one flags
  logic [15:0] flag_set;
  always_comb
  begin
    flag_set = 16'h0000;
    flag_set[ITC_IC1_OVA] = ova_trap;
    flag_set[ITC_IC1_OVB] = ovb_trap;
    flag_set[ITC_IC1_CVA] = cva_trap;
    flag_set[ITC_IC1_CVB] = cvb_trap;
    flag_set[ITC_IC1_SHIFT] = shift_err_evt;
    flag_set[ITC_IC1_DIV0] = div_zero_evt;
    flag_set[ITC_IC1_MATH] = math_trap;
    flag_set[ITC_IC1_ADDR] = addr_err_evt;
    flag_set[ITC_IC1_STACK] = stack_err_evt;
    flag_set[ITC_IC1_OSC] = osc_fail_evt;
  end

  // software only clears flags; a set in the same cycle wins
  wire [15:0] flag_keep = wr_ic1 ? (~wmask | wd) : 16'hFFFF;
  wire [15:0] next_ic1_flags = ((ic1_flags & flag_keep) | flag_set) & ITC_IC1_FLAG_MASK;
  wire [15:0] next_ic1_ctrl = wr_ic1 ? (((ic1_ctrl & ~wmask) | (wd & wmask)) & ITC_IC1_CTRL_MASK)
                                     : ic1_ctrl;
  wire [15:0] next_ic2_ctrl = wr_ic2 ? (((ic2_ctrl & ~wmask) | (wd & wmask)) & ITC_IC2_RW_MASK)
                                     : ic2_ctrl;
  wire next_var_lat = (wr_core && wmask[ITC_CC_VAR]) ? wd[ITC_CC_VAR] : var_lat;

  // extension bit: core load writes it from the level, software may only clear it
  wire ext_sw_clr = wr_core && wmask[ITC_CC_EXT] && !wd[ITC_CC_EXT];
  wire next_ext_bit = level_load ? (level_value > ITC_LEVEL_TOP_LOW) : (ext_bit && !ext_sw_clr);

  // low bits frozen to software while nesting is off; core still loads
  wire low_sw_ok = wr_stat && wmask[ITC_STAT_LOW_LSB] && !ic1_ctrl[ITC_IC1_NEST];
  wire [2:0] next_low_bits = level_load ? level_value[2:0]
                           : (low_sw_ok ? wd[ITC_STAT_LOW_LSB+2:ITC_STAT_LOW_LSB] : low_bits);

  // external pin edge detection, polarity per input
  logic [N_EXT-1:0] ext_edge;
  logic [N_EXT-1:0] next_ext_flag;
  genvar gi;
  generate
    for (gi = 0; gi < N_EXT; gi++)
    begin : g_ext
      wire fall = pin_prev[gi] && !sync_b[gi];
      wire rise = !pin_prev[gi] && sync_b[gi];
      assign ext_edge[gi] = ic2_ctrl[gi] ? fall : rise;
      wire clr = wr_ext && wr_strb[0] && !wr_data[gi];
      assign next_ext_flag[gi] = (ext_flag[gi] && !clr) || ext_edge[gi];
    end
  endgenerate

  // two-flop synchroniser and edge history for the pins
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
      pin_prev <= '0;
      ext_flag <= '0;
    end
    else
    begin
      sync_a <= ext_irq_pin;
      sync_b <= sync_a;
      pin_prev <= sync_b;
      ext_flag <= next_ext_flag;
    end
  end

  // control and status registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      var_lat <= 1'b0;
      ext_bit <= 1'b0;
      low_bits <= 3'h0;
      ic1_ctrl <= 16'h0000;
      ic1_flags <= 16'h0000;
      ic2_ctrl <= ITC_IC2_RESET;
      trap_seen <= 1'b0;
    end
    else
    begin
      var_lat <= next_var_lat;
      ext_bit <= next_ext_bit;
      low_bits <= next_low_bits;
      ic1_ctrl <= next_ic1_ctrl;
      ic1_flags <= next_ic1_flags;
      ic2_ctrl <= next_ic2_ctrl;
      trap_seen <= math_trap || addr_err_evt || stack_err_evt || osc_fail_evt || swt_trap;
    end
  end

  // write handshake state
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ITC_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr <= s_axi_awaddr[7:0];
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= wr_have_aw && !wr_fire;
      w_held <= wr_have_w && !wr_fire;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ITC_RESP_OKAY : ITC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read data views; unimplemented bits are zero
  wire [15:0] rd_core = {var_lat, 11'h000, ext_bit, 3'h0};
  wire [15:0] rd_ic1 = ic1_ctrl | ic1_flags;
  wire [15:0] rd_ic2 = ic2_ctrl | {1'b0, timed_disable_active, 14'h0000};
  wire [15:0] rd_stat = {8'h00, low_bits, 5'h00};
  wire [15:0] rd_ext = {{(16 - N_EXT){1'b0}}, ext_flag};
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_hit = (ra == ITC_OFF_CORE) || (ra == ITC_OFF_IC1) || (ra == ITC_OFF_IC2)
             || (ra == ITC_OFF_STATUS) || (ra == ITC_OFF_EXTFLAG);
  wire [15:0] rd_sel = (ra == ITC_OFF_CORE) ? rd_core
                     : (ra == ITC_OFF_IC1) ? rd_ic1
                     : (ra == ITC_OFF_IC2) ? rd_ic2
                     : (ra == ITC_OFF_STATUS) ? rd_stat
                     : (ra == ITC_OFF_EXTFLAG) ? rd_ext : 16'h0000;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_arready = !s_axi_rvalid;

  // read answer one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ITC_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_sel};
      s_axi_rresp <= rd_hit ? ITC_RESP_OKAY : ITC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // outputs to the core
  assign trap_request = trap_seen;
  assign ext_irq_flag = ext_flag;
  assign latency_variable = var_lat;
  assign cpu_priority_level = {ext_bit, low_bits};
  // traps bypass this gate entirely, only interrupts are held off
  assign irq_gate_open = ic2_ctrl[ITC_IC2_GLOBAL_EN] && !(ic1_ctrl[ITC_IC1_NEST] && irq_in_service);
  assign alternate_table_select = ic2_ctrl[ITC_IC2_ALT];
  assign software_trap_status = ic2_ctrl[ITC_IC2_SW_TRAP];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  chk_ext_level: assert property (level_load |=> (ext_bit == ($past(level_value) > 4'h7)))
    else $error("extension bit does not follow loaded level");
  chk_ext_no_set: assert property (!level_load && !ext_bit |=> !ext_bit)
    else $error("extension bit set without a core load");
  chk_low_frozen: assert property (ic1_ctrl[ITC_IC1_NEST] && !level_load |=> $stable(low_bits))
    else $error("low priority bits changed while nesting disabled");
  chk_nest_block: assert property (ic1_ctrl[ITC_IC1_NEST] && irq_in_service |-> !irq_gate_open)
    else $error("preemption allowed while nesting disabled");
  chk_gie_block: assert property (!ic2_ctrl[ITC_IC2_GLOBAL_EN] |-> !irq_gate_open)
    else $error("interrupt gate open with global enable low");
  chk_ova_gate: assert property (acc_a_ovf_evt && !ic1_ctrl[ITC_IC1_OVA_EN] && !ic1_flags[ITC_IC1_OVA]
    |=> !ic1_flags[ITC_IC1_OVA])
    else $error("overflow A flag set while its trap is disabled");
  chk_cat_flag: assert property (acc_b_cat_evt && ic1_ctrl[ITC_IC1_CAT_EN]
    |=> ic1_flags[ITC_IC1_CVB] && ic1_flags[ITC_IC1_MATH])
    else $error("catastrophic B trap did not set its flags");
  chk_div_flag: assert property (div_zero_evt |=> ic1_flags[ITC_IC1_DIV0] && ic1_flags[ITC_IC1_MATH])
    else $error("divide by zero did not set its flags");
  chk_addr_sticky: assert property (ic1_flags[ITC_IC1_ADDR] && !wr_ic1 |=> ic1_flags[ITC_IC1_ADDR])
    else $error("address trap flag dropped without a write");
  chk_trap_pulse: assert property (stack_err_evt |=> trap_request && ic1_flags[ITC_IC1_STACK])
    else $error("stack trap not raised within one cycle");
  chk_edge_flag: assert property (ext_edge[0] |=> ext_flag[0])
    else $error("external edge did not set its flag");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer not given one cycle after address");
  // gates, sticky flags and answers that the bench reaches only indirectly
  chk_software_trap_status_gate: assert property (sw_trap_evt && ic2_ctrl[ITC_IC2_SW_TRAP] |=> trap_request)
    else $error("enabled software trap not raised");
  chk_var_write: assert property (wr_core && wmask[ITC_CC_VAR] && wd[ITC_CC_VAR] |=> latency_variable)
    else $error("latency bit did not follow a write of one");
  chk_shift_flag: assert property (shift_err_evt |=> ic1_flags[ITC_IC1_SHIFT] && ic1_flags[ITC_IC1_MATH])
    else $error("shift error did not set its flags");
  chk_osc_flag: assert property (osc_fail_evt |=> ic1_flags[ITC_IC1_OSC])
    else $error("oscillator failure did not set its flag");
  chk_ext_no_spur: assert property (!ext_flag[0] && !ext_edge[0] |=> !ext_flag[0])
    else $error("external flag set without an edge");
  chk_gate_open: assert property (ic2_ctrl[ITC_IC2_GLOBAL_EN] && !irq_in_service |-> irq_gate_open)
    else $error("interrupt gate shut with global enable high and nothing in service");
  chk_ext_rise: assert property (!ic2_ctrl[N_EXT-1] && !pin_prev[N_EXT-1] && sync_b[N_EXT-1]
    |=> ext_flag[N_EXT-1])
    else $error("rising edge on the top pin did not set its flag");
  chk_write_answer: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write answer not given one cycle after execution");

  cov_math_trap: cover property (shift_err_evt ##1 trap_request);
  cov_flag_clear: cover property (ic1_flags[ITC_IC1_OSC] ##1 wr_ic1 ##1 !ic1_flags[ITC_IC1_OSC]);
  cov_ext_fall: cover property (ic2_ctrl[0] && ext_edge[0]);
  cov_level_hi: cover property (level_load && level_value > 4'h7);
  cov_nest_held: cover property (ic1_ctrl[ITC_IC1_NEST] && irq_in_service);

endmodule : itc_regs

`default_nettype wire

//--- testbench/interrupt_trap_control_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module interrupt_trap_control_regs_tb_top;
  import itc_pkg::*;
  logic sys_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, level_value, ext_irq_pin, cpu_priority_level, ext_irq_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] evt;
  logic level_load, irq_in_service, timed_disable_active, trap_request, latency_variable;
  logic irq_gate_open, alternate_table_select, software_trap_status;
  int fails, checks, cyc;
  logic [15:0] flag_tab [0:8] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090, 16'h0050, 16'h0008,
    16'h0004, 16'h0002};

  itc_regs #(.N_EXT(4)) DUT (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .acc_a_ovf_evt(evt[0]), .acc_b_ovf_evt(evt[1]), .acc_a_cat_evt(evt[2]), .acc_b_cat_evt(evt[3]),
    .shift_err_evt(evt[4]), .div_zero_evt(evt[5]), .addr_err_evt(evt[6]), .stack_err_evt(evt[7]),
    .osc_fail_evt(evt[8]), .sw_trap_evt(evt[9]), .level_load, .level_value, .irq_in_service,
    .timed_disable_active, .ext_irq_pin, .trap_request, .latency_variable, .cpu_priority_level,
    .irq_gate_open, .alternate_table_select, .software_trap_status, .ext_irq_flag);

  itc_core_model u_core (.sys_clk, .evt, .level_load, .level_value, .irq_in_service, .timed_disable_active,
    .ext_irq_pin);

  // 10 mhz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // write with both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (!ta && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (!tw && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
    end
    while (!(ta && tw));
    do @(posedge sys_clk); while (!s_axi_bvalid);
    // bready stays up, so a following call never lowers and raises it in one step
    `CHK(s_axi_bresp, er)
  endtask : wr

  // read and compare the whole word, upper half expected zero
  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    // rready stays up for the same reason
    `CHK(s_axi_rdata, {16'h0000, ed})
    `CHK(s_axi_rresp, er)
  endtask : rd

  // one trap pulse; request must last exactly one cycle
  task automatic trap(input logic [9:0] m, input logic ex);
    u_core.fire(m);
    #1 `CHK(trap_request, ex)
    @(posedge sys_clk);
    #1 `CHK(trap_request, 1'b0)
  endtask : trap

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'h3;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ITC_OFF_IC2, ITC_IC2_RESET, ITC_RESP_OKAY);
    rd(ITC_OFF_IC1, 16'h0000, ITC_RESP_OKAY);
    `CHK(irq_gate_open, 1'b1)
    wr(ITC_OFF_CORE, 16'hFFFF, ITC_RESP_OKAY);
    rd(ITC_OFF_CORE, 16'h8000, ITC_RESP_OKAY);
    `CHK(latency_variable, 1'b1)
    wr(ITC_OFF_CORE, 16'h0000, ITC_RESP_OKAY);
    `CHK(latency_variable, 1'b0)
    for (int v = 0; v < 16; v++)
    begin
      u_core.load(4'(v));
      #1 `CHK(cpu_priority_level, 4'(v))
      rd(ITC_OFF_CORE, {12'h000, v > 7, 3'h0}, ITC_RESP_OKAY);
      rd(ITC_OFF_STATUS, {8'h00, 3'(v), 5'h00}, ITC_RESP_OKAY);
    end
    wr(ITC_OFF_CORE, 16'h0000, ITC_RESP_OKAY);
    `CHK(cpu_priority_level, 4'h7)
    wr(ITC_OFF_IC1, 16'h8000, ITC_RESP_OKAY);
    wr(ITC_OFF_STATUS, 16'h0000, ITC_RESP_OKAY);
    rd(ITC_OFF_STATUS, 16'h00E0, ITC_RESP_OKAY);
    u_core.set(1'b1, 1'b0, 4'h0);
    #1 `CHK(irq_gate_open, 1'b0)
    wr(ITC_OFF_IC1, 16'h0000, ITC_RESP_OKAY);
    `CHK(irq_gate_open, 1'b1)
    wr(ITC_OFF_STATUS, 16'h0040, ITC_RESP_OKAY);
    `CHK(cpu_priority_level, 4'h2)
    // every trap cause but the software trap, with all overflow enables on
    wr(ITC_OFF_IC1, 16'h0700, ITC_RESP_OKAY);
    for (int i = 0; i < 9; i++)
    begin
      trap(10'(1 << i), 1'b1);
      wr(ITC_OFF_IC1, 16'h7FFF, ITC_RESP_OKAY);
      rd(ITC_OFF_IC1, 16'h0700 | flag_tab[i], ITC_RESP_OKAY);
      wr(ITC_OFF_IC1, 16'h0700, ITC_RESP_OKAY);
      rd(ITC_OFF_IC1, 16'h0700, ITC_RESP_OKAY);
    end
    wr(ITC_OFF_IC1, 16'h0400, ITC_RESP_OKAY);
    trap(10'h002, 1'b0);
    wr(ITC_OFF_IC1, 16'h0000, ITC_RESP_OKAY);
    trap(10'h00F, 1'b0);
    rd(ITC_OFF_IC1, 16'h0000, ITC_RESP_OKAY);
    // second control register fields
    wr(ITC_OFF_IC2, 16'hFFFF, ITC_RESP_OKAY);
    rd(ITC_OFF_IC2, 16'hA10F, ITC_RESP_OKAY);
    `CHK({alternate_table_select, software_trap_status}, 2'h3)
    trap(10'h200, 1'b1);
    u_core.set(1'b0, 1'b1, 4'h0);
    rd(ITC_OFF_IC2, 16'hE10F, ITC_RESP_OKAY);
    wr(ITC_OFF_IC2, 16'h0000, ITC_RESP_OKAY);
    `CHK(irq_gate_open, 1'b0)
    trap(10'h040, 1'b1);
    rd(ITC_OFF_IC1, 16'h0008, ITC_RESP_OKAY);
    trap(10'h200, 1'b0);
    `CHK(alternate_table_select, 1'b0)
    rd(ITC_OFF_IC2, 16'h4000, ITC_RESP_OKAY);
    // external edges: rising with polarity zero, falling with one
    wr(ITC_OFF_IC2, 16'h8000, ITC_RESP_OKAY);
    u_core.set(1'b0, 1'b0, 4'hF);
    repeat (5) @(posedge sys_clk);
    #1 `CHK(ext_irq_flag, 4'hF)
    wr(ITC_OFF_EXTFLAG, 16'h0000, ITC_RESP_OKAY);
    `CHK(ext_irq_flag, 4'h0)
    wr(ITC_OFF_IC2, 16'h800F, ITC_RESP_OKAY);
    u_core.set(1'b0, 1'b0, 4'h0);
    repeat (5) @(posedge sys_clk);
    #1 `CHK(ext_irq_flag, 4'hF)
    wr(ITC_OFF_EXTFLAG, 16'h0000, ITC_RESP_OKAY);
    u_core.set(1'b0, 1'b0, 4'hF);
    repeat (5) @(posedge sys_clk);
    #1 `CHK(ext_irq_flag, 4'h0)
    // unmapped offset answers with an error and reads zero
    wr(8'h14, 16'hFFFF, ITC_RESP_SLVERR);
    rd(8'h14, 16'h0000, ITC_RESP_SLVERR);
    results();
  end
endmodule : interrupt_trap_control_regs_tb_top

`default_nettype wire

//--- testbench/itc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// stands in for the cpu core and the trap-raising peripherals
module itc_core_model
(
  input wire logic sys_clk,
  output logic [9:0] evt,
  output logic level_load,
  output logic [3:0] level_value,
  output logic irq_in_service,
  output logic timed_disable_active,
  output logic [3:0] ext_irq_pin
);
  // quiet core at time zero
  initial
  begin
    evt = 10'h000;
    level_load = 1'b0;
    level_value = 4'h0;
    irq_in_service = 1'b0;
    timed_disable_active = 1'b0;
    ext_irq_pin = 4'h0;
  end

  // one-cycle trap pulses, so a held line never counts twice
  task automatic fire(input logic [9:0] m);
    @(posedge sys_clk);
    evt <= m;
    @(posedge sys_clk);
    evt <= 10'h000;
  endtask : fire

  // core priority update on its own pulse
  task automatic load(input logic [3:0] v);
    @(posedge sys_clk);
    level_load <= 1'b1;
    level_value <= v;
    @(posedge sys_clk);
    level_load <= 1'b0;
  endtask : load

  // levels held until changed; pins raise request flags only by edges
  task automatic set(input logic svc, input logic dis, input logic [3:0] pins);
    @(posedge sys_clk);
    irq_in_service <= svc;
    timed_disable_active <= dis;
    ext_irq_pin <= pins;
  endtask : set
endmodule : itc_core_model

`default_nettype wire
